// ===== verilog/slt_pkg.sv
// Constants and carrier types for the serial link transmitter register bank
package slt_pkg;

  // ==========================================================
  // Bus geometry
  localparam int SLT_ADDR_W = 14;
  localparam int SLT_IDX_W = 12;

  // ==========================================================
  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_SUBCLASS_WIDTH = 12'h590;
  localparam logic [11:0] IDX_FRAME_SAMPLES = 12'h591;
  localparam logic [11:0] IDX_DENSITY_CTRL = 12'h592;
  localparam logic [11:0] IDX_LANE0_CHECKSUM = 12'h5A0;
  localparam logic [11:0] IDX_LANE1_CHECKSUM = 12'h5A1;
  localparam logic [11:0] IDX_LANE_POWERDOWN = 12'h5B0;
  localparam logic [11:0] IDX_OUTPUT0_MAP = 12'h5B2;

  // ==========================================================
  // Field positions
  localparam int SUBCLASS_LSB = 5;
  localparam int HD_BIT = 7;
  localparam int PD_LANE0_BIT = 0;
  localparam int PD_LANE1_BIT = 2;
  localparam int MAP_RSVD_LSB = 4;

  // ==========================================================
  // Field encodings
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [4:0] SAMPLE_WIDTH_8 = 5'h07;
  localparam logic [4:0] SAMPLE_WIDTH_16 = 5'h0F;
  localparam logic [4:0] RESOLUTION_14 = 5'h0D;
  localparam logic [7:0] CONVERTERS_ONE = 8'h00;
  localparam logic [7:0] CONVERTERS_TWO = 8'h01;
  localparam logic [7:0] CONVERTERS_FOUR = 8'h03;
  localparam logic [2:0] LOGICAL_LANE_0 = 3'h0;
  localparam logic [2:0] LOGICAL_LANE_3 = 3'h3;

  // ==========================================================
  // Values after reset
  localparam logic [2:0] SUBCLASS_RESET = SUBCLASS_1;
  localparam logic [4:0] SAMPLE_WIDTH_RESET = SAMPLE_WIDTH_16;
  localparam logic [2:0] SAMPLES_RSVD_VALUE = 3'h1;
  localparam logic [7:0] CHECKSUM0_RESET = 8'hC3;
  localparam logic [7:0] CHECKSUM1_RESET = 8'hC4;
  localparam logic [7:0] POWERDOWN_RESET = 8'hFA;
  localparam logic [2:0] MAP_RSVD_RESET = 3'h0;
  localparam logic [2:0] MAP_LANE_RESET = LOGICAL_LANE_0;

  // ==========================================================
  // Link parameters held elsewhere in the transmitter
  typedef struct packed {
    logic [7:0] converters_per_link;
    logic [4:0] resolution;
    logic [4:0] samples_per_frame_m1;
    logic high_density_flag;
    logic [4:0] control_words_per_frame;
    logic [7:0] other_param_sum;
    logic [2:0] lane1_logical_id;
  } slt_link_params_t;

  // Controls handed to the serializer
  typedef struct packed {
    logic lane0_powerdown;
    logic lane1_powerdown;
    logic [2:0] output0_lane_sel;
    logic [2:0] subclass;
    logic [4:0] sample_width;
  } slt_link_ctrl_t;

endpackage

// ===== verilog/slt_link_tx_regs.sv
// Register bank for the serial link transmitter, reached over APB
`timescale 1ns/10ps

// Behaviour
// - Subclass field bits 7:5, resets subclass 1
// - Writable sample width bits 4:0, resets 16
// - Read-only samples per frame, count is value+1
// - Read-only high density flag bit 7, reset 0
// - Read-only control words per frame, no offset
// - Lane 0 checksum sum mod 256, reset C3
// - Lane 1 checksum sum mod 256, reset C4
// - Power-down bit 0 forces lane 0 off
// - Power-down bit 2 forces lane 1 off
// - Three-bit field routes output 0 lane
// - Five-bit resolution code feeds the checksums
// - Converter count code feeds the checksums
module slt_link_tx_regs
  import slt_pkg::*;
#(
  parameter int LANE_W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SLT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link parameters from the rest of the transmitter
  input wire slt_link_params_t link_params,
  // Logical lane data ahead of the serializer
  input wire logic [4*LANE_W-1:0] logical_lane_data,
  // Serializer controls and lane 0 data
  output slt_link_ctrl_t link_ctrl,
  output logic [LANE_W-1:0] serial_output_pair_0
);

  // ==========================================================
  // Storage
  logic [2:0] subclass;
  logic [4:0] sample_width;
  logic [4:0] samples_per_frame_m1;
  logic high_density_flag;
  logic [4:0] control_words_per_frame;
  logic [7:0] lane0_checksum;
  logic [7:0] lane1_checksum;
  logic [7:0] powerdown;
  logic [2:0] map_reserved;
  logic [2:0] output0_lane_sel;

  // ==========================================================
  // Next values, worked out by the combinational logic below
  logic [2:0] next_subclass;
  logic [4:0] next_sample_width;
  logic [4:0] next_samples_per_frame_m1;
  logic next_high_density_flag;
  logic [4:0] next_control_words_per_frame;
  logic [7:0] next_powerdown;
  logic [2:0] next_map_reserved;
  logic [2:0] next_output0_lane_sel;
  logic [7:0] next_read_byte;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ==========================================================
  // APB decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire aligned = (paddr[1:0] == 2'h0);
  wire [SLT_IDX_W-1:0] word_idx = paddr[SLT_ADDR_W-1:2];

  wire hit_subclass = aligned & (word_idx == IDX_SUBCLASS_WIDTH);
  wire hit_samples = aligned & (word_idx == IDX_FRAME_SAMPLES);
  wire hit_density = aligned & (word_idx == IDX_DENSITY_CTRL);
  wire hit_chk0 = aligned & (word_idx == IDX_LANE0_CHECKSUM);
  wire hit_chk1 = aligned & (word_idx == IDX_LANE1_CHECKSUM);
  wire hit_pd = aligned & (word_idx == IDX_LANE_POWERDOWN);
  wire hit_map = aligned & (word_idx == IDX_OUTPUT0_MAP);

  wire hit_rw = hit_subclass | hit_pd | hit_map;
  wire hit_ro = hit_samples | hit_density | hit_chk0 | hit_chk1;
  wire mapped = hit_rw | hit_ro;

  // A write to a read-only or absent word is flagged, never stored
  wire bad_access = ~mapped | (pwrite & hit_ro);

  // Only byte lane 0 carries data; a write without it changes nothing
  wire wr_lane0 = access_phase & pwrite & pstrb[0];
  wire wr_subclass = wr_lane0 & hit_subclass;
  wire wr_pd = wr_lane0 & hit_pd;
  wire wr_map = wr_lane0 & hit_map;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // ==========================================================
  // Read views of each register
  wire [7:0] view_subclass = {subclass, sample_width};
  wire [7:0] view_samples = {SAMPLES_RSVD_VALUE, samples_per_frame_m1};
  wire [7:0] view_density = {high_density_flag, 2'h0, control_words_per_frame};
  wire [7:0] view_map = {1'b0, map_reserved, 1'b0, output0_lane_sel};

  // Read select; the hits are one-hot, and a miss reads as zero
  always_comb begin
    next_read_byte = 8'h00;
    if (hit_subclass) begin
      next_read_byte = view_subclass;
    end else if (hit_samples) begin
      next_read_byte = view_samples;
    end else if (hit_density) begin
      next_read_byte = view_density;
    end else if (hit_chk0) begin
      next_read_byte = lane0_checksum;
    end else if (hit_chk1) begin
      next_read_byte = lane1_checksum;
    end else if (hit_pd) begin
      next_read_byte = powerdown;
    end else if (hit_map) begin
      next_read_byte = view_map;
    end
  end

  // A write or a refused access returns zero, so no stale byte leaks out
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = bad_access;
    if (!pwrite && !bad_access) begin
      next_prdata = {24'h00_0000, next_read_byte};
    end
  end

  // Read data and error are captured in the setup cycle, so both come
  // from flops and stand steady through the access cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Subclass and sample width
  // Any three-bit subclass code is kept; only codes 0 and 1 are meaningful
  always_comb begin
    next_subclass = subclass;
    next_sample_width = sample_width;
    if (wr_subclass) begin
      next_subclass = pwdata[SUBCLASS_LSB +: 3];
      next_sample_width = pwdata[4:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      subclass <= SUBCLASS_RESET;
      sample_width <= SAMPLE_WIDTH_RESET;
    end else begin
      subclass <= next_subclass;
      sample_width <= next_sample_width;
    end
  end

  // ==========================================================
  // Read-only link parameters, sampled from the transmitter each cycle
  // A snapshot costs one cycle of lag but keeps the read path flop-driven
  always_comb begin
    next_samples_per_frame_m1 = link_params.samples_per_frame_m1;
    next_high_density_flag = link_params.high_density_flag;
    next_control_words_per_frame = link_params.control_words_per_frame;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      samples_per_frame_m1 <= 5'h00;
      high_density_flag <= 1'b0;
      control_words_per_frame <= 5'h00;
    end else begin
      samples_per_frame_m1 <= next_samples_per_frame_m1;
      high_density_flag <= next_high_density_flag;
      control_words_per_frame <= next_control_words_per_frame;
    end
  end

  // ==========================================================
  // Lane checksums
  // Every link parameter of a lane summed with 8-bit wrap, which is the
  // modulo 256 sum; the lane id is the only term that differs per lane
  function automatic logic [7:0] lane_sum(
    input slt_link_params_t p,
    input logic [2:0] subcl,
    input logic [4:0] width,
    input logic [2:0] lane_id
  );
    logic [7:0] s;
    s = p.converters_per_link;
    s = s + {3'h0, p.resolution};
    s = s + {3'h0, p.samples_per_frame_m1};
    s = s + {7'h00, p.high_density_flag};
    s = s + {3'h0, p.control_words_per_frame};
    s = s + {5'h00, subcl};
    s = s + {3'h0, width};
    s = s + {5'h00, lane_id};
    s = s + p.other_param_sum;
    return s;
  endfunction

  wire [7:0] next_lane0_checksum =
    lane_sum(link_params, subclass, sample_width, output0_lane_sel);
  wire [7:0] next_lane1_checksum =
    lane_sum(link_params, subclass, sample_width, link_params.lane1_logical_id);

  // Recomputed every cycle, so a read trails a change by one cycle at most
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lane0_checksum <= CHECKSUM0_RESET;
    end else begin
      lane0_checksum <= next_lane0_checksum;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lane1_checksum <= CHECKSUM1_RESET;
    end else begin
      lane1_checksum <= next_lane1_checksum;
    end
  end

  // ==========================================================
  // Lane power-down
  // Reserved bits are stored as written; software keeps them at reset
  always_comb begin
    next_powerdown = powerdown;
    if (wr_pd) begin
      next_powerdown = pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      powerdown <= POWERDOWN_RESET;
    end else begin
      powerdown <= next_powerdown;
    end
  end

  // ==========================================================
  // Output 0 lane assignment
  // Bits 7 and 3 are not stored and read back as zero
  always_comb begin
    next_map_reserved = map_reserved;
    next_output0_lane_sel = output0_lane_sel;
    if (wr_map) begin
      next_map_reserved = pwdata[MAP_RSVD_LSB +: 3];
      next_output0_lane_sel = pwdata[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      map_reserved <= MAP_RSVD_RESET;
      output0_lane_sel <= MAP_LANE_RESET;
    end else begin
      map_reserved <= next_map_reserved;
      output0_lane_sel <= next_output0_lane_sel;
    end
  end

  // ==========================================================
  // Serializer controls
  assign link_ctrl.lane0_powerdown = powerdown[PD_LANE0_BIT];
  assign link_ctrl.lane1_powerdown = powerdown[PD_LANE1_BIT];
  assign link_ctrl.output0_lane_sel = output0_lane_sel;
  assign link_ctrl.subclass = subclass;
  assign link_ctrl.sample_width = sample_width;

  // ==========================================================
  // Lane 0 routing
  // Codes above logical lane 3 select nothing and the pair idles at zero
  wire lane_sel_valid = (output0_lane_sel <= LOGICAL_LANE_3);
  wire [LANE_W-1:0] lane_word_0 = logical_lane_data[0*LANE_W +: LANE_W];
  wire [LANE_W-1:0] lane_word_1 = logical_lane_data[1*LANE_W +: LANE_W];
  wire [LANE_W-1:0] lane_word_2 = logical_lane_data[2*LANE_W +: LANE_W];
  wire [LANE_W-1:0] lane_word_3 = logical_lane_data[3*LANE_W +: LANE_W];

  // Only the low two bits steer the mux; the validity check gates the rest
  logic [LANE_W-1:0] routed_lane;
  always_comb begin
    routed_lane = lane_word_0;
    unique case (output0_lane_sel[1:0])
      2'h0: routed_lane = lane_word_0;
      2'h1: routed_lane = lane_word_1;
      2'h2: routed_lane = lane_word_2;
      2'h3: routed_lane = lane_word_3;
    endcase
  end

  wire [LANE_W-1:0] next_pair_0 =
    (lane_sel_valid & ~powerdown[PD_LANE0_BIT]) ? routed_lane : '0;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_output_pair_0 <= '0;
    end else begin
      serial_output_pair_0 <= next_pair_0;
    end
  end

endmodule

// ===== dv/slt_lane_source.sv
// Far-side model: logical lane data source ahead of the serializer
`timescale 1ns/10ps
module slt_lane_source #(
  parameter int LANE_W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Lane data, lane number in the top two bits
  output logic [4*LANE_W-1:0] logical_lane_data
);
  logic [LANE_W-3:0] cnt;
  always_ff @(posedge mclk) begin
    cnt <= sys_rst ? '0 : cnt + 1'b1;
  end
  // Changes every cycle so a stale or wrong pick shows up
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      logical_lane_data[n*LANE_W +: LANE_W] = {2'(n), cnt};
    end
  end
endmodule

// ===== dv/slt_regs_assertions.sv
// Checker for the transmitter register bank
`timescale 1ns/10ps
module slt_regs_checker
  import slt_pkg::*;
#(
  parameter int LANE_W = 10
) (
  // Clock, reset and APB
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SLT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link side
  input wire slt_link_params_t link_params,
  input wire logic [4*LANE_W-1:0] logical_lane_data,
  input wire slt_link_ctrl_t link_ctrl,
  input wire logic [LANE_W-1:0] serial_output_pair_0
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire wr = psel && penable && pwrite && pstrb[0];
  wire rd = psel && penable && !pwrite;
  wire [LANE_W-1:0] pick = LANE_W'(logical_lane_data >> (LANE_W * link_ctrl.output0_lane_sel));
  wire off = link_ctrl.output0_lane_sel > 3'h3 || link_ctrl.lane0_powerdown;
  // ==========================================================
  // Properties
  property p_rst; $fell(sys_rst) |-> link_ctrl == 14'h002F; endproperty
  a_rst: assert property (p_rst) else $error("bad controls after reset");
  property p_wid; wr && paddr == 14'h1640 |=> link_ctrl[7:0] == $past(pwdata[7:0]); endproperty
  a_wid: assert property (p_wid) else $error("subclass or width not stored");
  property p_spf; rd && paddr == 14'h1644 |->
    prdata[7:0] == {3'h1, $past(link_params.samples_per_frame_m1, 2)}; endproperty
  a_spf: assert property (p_spf) else $error("samples field wrong");
  property p_cf; rd && paddr == 14'h1648 |-> prdata[7:0] == {$past(link_params.high_density_flag, 2),
    2'h0, $past(link_params.control_words_per_frame, 2)}; endproperty
  a_cf: assert property (p_cf) else $error("density field wrong");
  property p_pd0; wr && paddr == 14'h16C0 |=> link_ctrl.lane0_powerdown == $past(pwdata[0]);
  endproperty
  a_pd0: assert property (p_pd0) else $error("lane 0 power-down wrong");
  property p_pd1; wr && paddr == 14'h16C0 |=> link_ctrl.lane1_powerdown == $past(pwdata[2]);
  endproperty
  a_pd1: assert property (p_pd1) else $error("lane 1 power-down wrong");
  property p_map; wr && paddr == 14'h16C8 |=> link_ctrl.output0_lane_sel == $past(pwdata[2:0]);
  endproperty
  a_map: assert property (p_map) else $error("lane select not stored");
  property p_route; !sys_rst && !off |=> serial_output_pair_0 == $past(pick); endproperty
  a_route: assert property (p_route) else $error("output 0 carries wrong lane");
  property p_off; !sys_rst && off |=> serial_output_pair_0 == '0; endproperty
  a_off: assert property (p_off) else $error("output 0 not quiet");
endmodule
bind slt_link_tx_regs slt_regs_checker #(.LANE_W(LANE_W)) u_chk (.mclk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .link_params, .logical_lane_data,
  .link_ctrl, .serial_output_pair_0);

// ===== dv/tb_slt_link_tx_regs.sv
// Testbench for the transmitter register bank
`timescale 1ns/10ps
module tb_slt_link_tx_regs import slt_pkg::*; ;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [3:0] pstrb = 4'hF;
  logic [39:0] logical_lane_data;
  logic [9:0] serial_output_pair_0;
  slt_link_params_t link_params = '0;
  slt_link_ctrl_t link_ctrl;
  int fails = 0, checked = 0;
  always #20 mclk = ~mclk;
  slt_link_tx_regs uut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .link_params, .logical_lane_data, .link_ctrl, .serial_output_pair_0);
  slt_lane_source far (.mclk, .sys_rst, .logical_lane_data);
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic [13:0] a, input logic w, input logic [7:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      complete_run;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic x);
    apb(a, 1, d);
    chk(e, x);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] d, input logic x);
    apb(a, 0, 8'h0);
    chk(q, d);
    chk(e, x);
  endtask
  function automatic logic [7:0] csum(input logic [2:0] id, input logic [2:0] s,
    input logic [4:0] w);
    return link_params.converters_per_link + link_params.resolution + s + w + id
      + link_params.samples_per_frame_m1 + link_params.high_density_flag
      + link_params.control_words_per_frame + link_params.other_param_sum;
  endfunction
  // ==========================================================
  // Sequence
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 0;
    link_params <= '{CONVERTERS_FOUR, RESOLUTION_14, 5'h03, 1'b1, 5'h02, 8'h40, 3'h1};
    repeat (3) @(posedge mclk);
    chk(link_ctrl, 32'h2F);
    rd(14'h1640, 32'h2F, 0);
    rd(14'h16C0, 32'hFA, 0);
    rd(14'h1644, 32'h23, 0);
    rd(14'h1648, 32'h82, 0);
    wr(14'h1648, 8'hFF, 1);
    rd(14'h1648, 32'h82, 0);
    rd(14'h1684, csum(3'h1, 3'h1, 5'h0F), 0);
    for (int i = 0; i < 3; i++) begin
      link_params.converters_per_link <= i == 0 ? CONVERTERS_ONE : i == 1 ? CONVERTERS_TWO
        : CONVERTERS_FOUR;
      @(posedge mclk);
      rd(14'h1680, csum(3'h0, 3'h1, 5'h0F), 0);
    end
    wr(14'h1640, {SUBCLASS_0, SAMPLE_WIDTH_8}, 0);
    rd(14'h1680, csum(3'h0, 3'h0, 5'h07), 0);
    pstrb <= 4'h0;
    wr(14'h1640, 8'hFF, 0);
    pstrb <= 4'hF;
    rd(14'h1640, 32'h07, 0);
    wr(14'h1640, 8'h2F, 0);
    wr(14'h16C0, 8'hFB, 0);
    @(posedge mclk);
    chk(serial_output_pair_0, 0);
    wr(14'h16C0, 8'hFE, 0);
    chk(link_ctrl, 32'h082F);
    for (int n = 0; n < 5; n++) begin
      wr(14'h16C8, 8'(n), 0);
      @(posedge mclk);
      chk(n < 4 ? serial_output_pair_0[9:8] : serial_output_pair_0, n < 4 ? n : 0);
      rd(14'h1680, csum(3'(n), 3'h1, 5'h0F), 0);
    end
    wr(14'h16C8, 8'h03, 0);
    rd(14'h16C8, 32'h03, 0);
    rd(14'h1650, 32'h0, 1);
    rd(14'h1641, 32'h0, 1);
    complete_run;
  end
endmodule
